// ===== i2c_seq_exec.sv
// i2c command executor of the sequencer: start, stop, write, read
// assumes a one-cycle-latency sequencer sram on the same clock and
// open-drain i2c pins resolved outside
`timescale 1ns/1ps
module i2c_seq_exec (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // run request
    input wire logic run_start,
    input wire logic [8:0] start_addr,
    input wire logic [9:0] sequence_length,
    output logic busy_q,
    output logic done_q,
    output logic err_q,
    output logic nack_seen_q,
    // host link gate
    input wire logic link_rx_valid,
    output logic link_rx_ready_q,
    // sequencer sram
    output logic [8:0] mem_addr_q,
    output logic mem_re_q,
    output logic mem_we_q,
    output logic [7:0] mem_wdata_q,
    input wire logic [7:0] mem_rdata,
    // i2c pins
    input wire logic scl_in,
    output logic scl_out_q,
    output logic scl_oe_q,
    input wire logic sda_in,
    output logic sda_out_q,
    output logic sda_oe_q
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        IDLE, FETCH, MWAIT, TAKE_OP, TAKE_LEN, TAKE_DAT,
        START, STOP, BIT, DRAIN
    } state_t;

    state_t state_q;
    state_t ret_q;
    logic [9:0] pc_q;
    logic [9:0] end_q;
    logic [7:0] op_q;
    logic [8:0] cnt_q;
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic [1:0] phase_q;
    logic [7:0] tmr_q;
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_s;
    logic sda_s;
    logic is_read;
    logic phase_done;
    logic byte_end;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [i2c_seq_pkg::FIFO_WIDTH-1:0] fifo_out_data;
    logic push;
    logic over;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // pin synchronisers and step timing
    // ------------------------------------------------------------
    // two flops on each pin before any logic reads it
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
        end
    end
    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];

    assign is_read = op_q == i2c_seq_pkg::OP_READ;
    assign byte_end = bit_q == i2c_seq_pkg::LAST_BIT;
    // a quarter ends on timeout; high phase waits for a stretched clock;
    // the last quarter of a read byte waits for room in the fifo
    assign phase_done = tmr_q == 8'h00 && (phase_q != 2'h1 || scl_s)
        && !(state_q == BIT && phase_q == 2'h3 && byte_end && is_read
        && !fifo_in_ready);
    assign push = state_q == BIT && phase_q == 2'h3 && byte_end
        && is_read && phase_done;
    // one spare bit so a long length cannot wrap past the limit
    assign over = ({2'b00, start_addr} + {1'b0, sequence_length})
        > 11'(i2c_seq_pkg::SEQ_MEM_BYTES);

    // quarter-period timer, reloaded at each quarter boundary
    always_ff @(posedge clk) begin
        if (rst) begin
            tmr_q <= i2c_seq_pkg::QTR_RELOAD;
        end else if (state_q != START && state_q != STOP && state_q != BIT) begin
            tmr_q <= i2c_seq_pkg::QTR_RELOAD;
        end else if (phase_done) begin
            tmr_q <= i2c_seq_pkg::QTR_RELOAD;
        end else if (tmr_q != 8'h00) begin
            tmr_q <= tmr_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // command sequencing
    // ------------------------------------------------------------
    // main state machine walking the stored packets
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= IDLE;
            ret_q <= TAKE_OP;
            pc_q <= '0;
            end_q <= '0;
            op_q <= '0;
            cnt_q <= '0;
            phase_q <= i2c_seq_pkg::PHASE_RST;
            bit_q <= '0;
        end else begin
            unique case (state_q)
                IDLE: begin
                    if (run_start && !over) begin
                        pc_q <= {1'b0, start_addr};
                        end_q <= {1'b0, start_addr} + sequence_length;
                        ret_q <= TAKE_OP;
                        state_q <= FETCH;
                    end
                end
                FETCH: begin
                    if (pc_q == end_q) begin
                        state_q <= DRAIN;
                    end else begin
                        state_q <= MWAIT;
                    end
                end
                MWAIT: begin
                    state_q <= ret_q;
                end
                TAKE_OP: begin
                    op_q <= mem_rdata;
                    pc_q <= pc_q + 10'h001;
                    phase_q <= i2c_seq_pkg::PHASE_RST;
                    ret_q <= TAKE_LEN;
                    unique case (mem_rdata)
                        i2c_seq_pkg::OP_START: state_q <= START;
                        i2c_seq_pkg::OP_STOP: state_q <= STOP;
                        i2c_seq_pkg::OP_WRITE: state_q <= FETCH;
                        i2c_seq_pkg::OP_READ: state_q <= FETCH;
                        default: state_q <= DRAIN;
                    endcase
                end
                TAKE_LEN: begin
                    cnt_q <= mem_rdata == 8'h00 ?
                        i2c_seq_pkg::ZERO_LEN_COUNT : {1'b0, mem_rdata};
                    pc_q <= pc_q + 10'h001;
                    bit_q <= '0;
                    phase_q <= i2c_seq_pkg::PHASE_RST;
                    ret_q <= TAKE_DAT;
                    state_q <= is_read ? BIT : FETCH;
                end
                TAKE_DAT: begin
                    pc_q <= pc_q + 10'h001;
                    bit_q <= '0;
                    phase_q <= i2c_seq_pkg::PHASE_RST;
                    state_q <= BIT;
                end
                START, STOP: begin
                    if (phase_done) begin
                        phase_q <= phase_q + 2'h1;
                        if (phase_q == 2'h3) begin
                            ret_q <= TAKE_OP;
                            state_q <= FETCH;
                        end
                    end
                end
                BIT: begin
                    if (phase_done) begin
                        phase_q <= phase_q + 2'h1;
                        if (phase_q == 2'h3 && !byte_end) begin
                            bit_q <= bit_q + 4'h1;
                        end else if (phase_q == 2'h3) begin
                            bit_q <= '0;
                            cnt_q <= cnt_q - 9'h001;
                            if (is_read) begin
                                pc_q <= pc_q + 10'h001;
                            end
                            if (cnt_q == 9'h001) begin
                                ret_q <= TAKE_OP;
                                state_q <= FETCH;
                            end else if (!is_read) begin
                                state_q <= FETCH;
                            end
                        end
                    end
                end
                DRAIN: begin
                    if (!fifo_out_valid && !mem_we_q) begin
                        state_q <= IDLE;
                    end
                end
            endcase
        end
    end

    // run status and host link gate
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            link_rx_ready_q <= 1'b1;
        end else begin
            done_q <= state_q == DRAIN && !fifo_out_valid && !mem_we_q;
            err_q <= (state_q == IDLE && run_start && over)
                || (state_q == TAKE_OP && mem_rdata != i2c_seq_pkg::OP_START
                && mem_rdata != i2c_seq_pkg::OP_STOP
                && mem_rdata != i2c_seq_pkg::OP_WRITE
                && mem_rdata != i2c_seq_pkg::OP_READ);
            busy_q <= state_q == IDLE ? run_start && !over : !done_q;
            // host traffic is refused from the launch until done, except in the cycle after a launch made while done_q is high
            link_rx_ready_q <= state_q == IDLE && !(run_start && !over)
                || done_q;
        end
    end

    // ------------------------------------------------------------
    // i2c bit engine
    // ------------------------------------------------------------
    // shift register: loaded from sram on write, filled from sda on read
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= 8'hFF;
            nack_seen_q <= 1'b0;
        end else if (state_q == IDLE && run_start) begin
            nack_seen_q <= 1'b0;
        end else if (state_q == TAKE_DAT) begin
            shift_q <= mem_rdata;
        end else if (state_q == BIT && phase_done && phase_q == 2'h2) begin
            if (is_read && !byte_end) begin
                shift_q <= {shift_q[6:0], sda_s};
            end else if (!is_read && byte_end) begin
                nack_seen_q <= nack_seen_q | sda_s;
            end
        end else if (state_q == BIT && phase_done && phase_q == 2'h3
            && !is_read && !byte_end) begin
            shift_q <= {shift_q[6:0], 1'b0};
        end
    end

    // open-drain pin drive per quarter
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_out_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            scl_out_q <= 1'b0;
            sda_out_q <= 1'b0;
            if (state_q == START) begin
                if (phase_q == 2'h0) sda_oe_q <= 1'b0;
                if (phase_q == 2'h1) scl_oe_q <= 1'b0;
                if (phase_q == 2'h2) sda_oe_q <= 1'b1;
                if (phase_q == 2'h3) scl_oe_q <= 1'b1;
            end else if (state_q == STOP) begin
                if (phase_q == 2'h0) sda_oe_q <= 1'b1;
                if (phase_q == 2'h1) scl_oe_q <= 1'b0;
                if (phase_q == 2'h2) sda_oe_q <= 1'b0;
            end else if (state_q == BIT) begin
                if (phase_q == 2'h0) begin
                    sda_oe_q <= byte_end ? is_read : !is_read && !shift_q[7];
                end
                if (phase_q == 2'h1) scl_oe_q <= 1'b0;
                if (phase_q == 2'h3) scl_oe_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read data path into sram
    // ------------------------------------------------------------
    seq_fifo #(
        .WIDTH(i2c_seq_pkg::FIFO_WIDTH),
        .DEPTH(i2c_seq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({pc_q[8:0], shift_q}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // writes only when the sequencer is not issuing a fetch
    assign fifo_out_ready = state_q != FETCH;

    // single sram port shared by fetches and read-array writes
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_addr_q <= '0;
            mem_re_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_wdata_q <= '0;
        end else begin
            mem_re_q <= state_q == FETCH && pc_q != end_q;
            mem_we_q <= fifo_out_valid && fifo_out_ready;
            if (state_q == FETCH) begin
                mem_addr_q <= pc_q[8:0];
            end else if (fifo_out_valid) begin
                mem_addr_q <= fifo_out_data[16:8];
                mem_wdata_q <= fifo_out_data[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_start;
        state_q == TAKE_OP && mem_rdata == i2c_seq_pkg::OP_START
            |=> state_q == START ##1 !sda_oe_q;
    endproperty
    a_start: assert property (p_start) else $error("no start");

    property p_stop;
        state_q == TAKE_OP && mem_rdata == i2c_seq_pkg::OP_STOP
            |=> state_q == STOP ##1 sda_oe_q;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");

    property p_gate;
        busy_q |-> !link_rx_ready_q;
    endproperty
    a_gate: assert property (p_gate) else $error("link open");

    property p_wdat;
        state_q == TAKE_DAT |=> state_q == BIT && shift_q == $past(mem_rdata);
    endproperty
    a_wdat: assert property (p_wdat) else $error("bad write byte");

    property p_len;
        state_q == TAKE_LEN |=> cnt_q == ($past(mem_rdata) == 8'h00 ?
            9'h100 : {1'b0, $past(mem_rdata)});
    endproperty
    a_len: assert property (p_len) else $error("bad length");

    property p_push;
        push |=> pc_q == $past(pc_q) + 10'h001;
    endproperty
    a_push: assert property (p_push) else $error("slot skipped");

    property p_wack;
        state_q == BIT && !is_read && byte_end && phase_q == 2'h2
            |-> !sda_oe_q;
    endproperty
    a_wack: assert property (p_wack) else $error("sda held at ack");

    property p_rack;
        state_q == BIT && is_read && byte_end && phase_q == 2'h2 |-> sda_oe_q;
    endproperty
    a_rack: assert property (p_rack) else $error("no master ack");

    property p_fetch;
        state_q == FETCH && pc_q != end_q
            |=> mem_re_q && {1'b0, mem_addr_q} == $past(pc_q);
    endproperty
    a_fetch: assert property (p_fetch) else $error("bad fetch");

    property p_over;
        state_q == IDLE && run_start && over |=> err_q && state_q == IDLE;
    endproperty
    a_over: assert property (p_over) else $error("overrun ran");
endmodule

// ===== i2c_seq_pkg.sv
// shared constants for the i2c command sequencer
// assumes a 25 MHz core clock and a sequencer memory of 512 bytes
package i2c_seq_pkg;
    // ------------------------------------------------------------
    // opcodes and memory
    // ------------------------------------------------------------
    localparam logic [7:0] OP_START = 8'h02;
    localparam logic [7:0] OP_STOP = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'hE3;
    localparam logic [7:0] OP_READ = 8'hD4;
    localparam int SEQ_MEM_BYTES = 512;
    localparam int ADDR_W = 9;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = ADDR_W + 8;
    localparam logic [8:0] ZERO_LEN_COUNT = 9'h100; // length 0 means 256
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int I2C_PERIOD_NS = 10000; // 100 kHz standard mode
    localparam int QTR_CYCLES = I2C_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [7:0] QTR_RELOAD = 8'(QTR_CYCLES - 1);
    // ------------------------------------------------------------
    // value after reset and the last bit index
    // ------------------------------------------------------------
    localparam logic [1:0] PHASE_RST = 2'h0;
    localparam logic [3:0] LAST_BIT = 4'h8;
endpackage

// ===== seq_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/1ps
module seq_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    // refuse depths that the wrapping pointers cannot serve
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("seq_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0] wr_q;
    logic [PW:0] rd_q;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = (wr_q ^ rd_q) != {1'b1, {PW{1'b0}}};
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[PW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // write side
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    // storage array, no reset needed for data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[PW-1:0]] <= in_data;
        end
    end

    // read side
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule

// ===== i2c_slave_model.sv
// i2c slave model standing on the far side of the command executor
// assumes open-drain wires with pull-ups resolved by the bench
`timescale 1ns/1ps
module i2c_slave_model (
    // resolved bus levels
    input wire logic scl,
    input wire logic sda,
    // pulls toward ground
    output logic scl_pull,
    output logic sda_pull
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic ack_q[$];
    logic [7:0] sh;
    logic rd = 1'b0;
    logic first = 1'b0;
    logic nack_en = 1'b0;
    logic strong_pullup = 1'b0; // raised by the bench while powered
    int stretch_ns = 0;
    int bit_n = -1;
    int starts = 0;
    int stops = 0;
    // bus released at time zero
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // start and stop conditions frame the bytes
    always @(sda) begin
        if (scl === 1'b1) begin
            bit_n = sda ? -1 : 0;
            first = 1'b1;
            rd = 1'b0;
            if (sda)
                stops++;
            else
                starts++;
        end
    end
    // shift in master bits, note the master acknowledge
    always @(posedge scl) begin
        if (bit_n >= 0) begin
            if (rd && !first) begin
                if (bit_n == 8)
                    ack_q.push_back(sda);
                if (bit_n == 7 && tx_q.size() > 0)
                    tx_q.delete(0);
            end else if (bit_n < 8) begin
                sh = {sh[6:0], sda};
                if (bit_n == 7)
                    rx_q.push_back(sh);
                if (bit_n == 7 && first)
                    rd = sh[0];
            end
            first = first && bit_n != 8;
            bit_n = (bit_n + 1) % 9;
        end
    end
    // acknowledge or present data while the clock is low; may stretch
    always @(negedge scl) begin
        if (bit_n == 8 && !(rd && !first))
            sda_pull = strong_pullup && !(nack_en && !first);
        else if (rd && !first && bit_n >= 0 && bit_n < 8 && tx_q.size() > 0)
            sda_pull = !tx_q[0][7 - bit_n];
        else
            sda_pull = 1'b0;
        scl_pull = stretch_ns > 0;
        #(stretch_ns);
        scl_pull = 1'b0;
    end
endmodule

// ===== testbench.sv
// self-checking bench for the i2c command executor and its fifo
// assumes the design files and the slave model compile first
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // signals and models
    // ------------------------------------------------------------
    logic clk, rst, run_start;
    logic [8:0] start_addr;
    logic [9:0] sequence_length;
    logic busy_q, done_q, err_q, nack_seen_q;
    logic link_rx_valid, link_rx_ready_q, mem_re_q, mem_we_q;
    logic [8:0] mem_addr_q;
    logic [7:0] mem_wdata_q;
    logic [7:0] mem_rdata = 8'h00;
    logic scl_out_q, scl_oe_q, sda_out_q, sda_oe_q, scl_pull, sda_pull;
    logic [7:0] mem [512];
    logic [7:0] seq_q[$];
    logic [16:0] exp_wr[$];
    logic [31:0] seed = 32'h0000_5318;
    int mismatches = 0;
    int tests_run = 0;
    wire scl_w = !(scl_oe_q || scl_pull);
    wire sda_w = !(sda_oe_q || sda_pull);

    i2c_seq_exec dut_u (
        .clk(clk), .rst(rst), .run_start(run_start),
        .start_addr(start_addr), .sequence_length(sequence_length),
        .busy_q(busy_q), .done_q(done_q), .err_q(err_q),
        .nack_seen_q(nack_seen_q), .link_rx_valid(link_rx_valid),
        .link_rx_ready_q(link_rx_ready_q), .mem_addr_q(mem_addr_q),
        .mem_re_q(mem_re_q), .mem_we_q(mem_we_q),
        .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata),
        .scl_in(scl_w), .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q),
        .sda_in(sda_w), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q)
    );
    i2c_slave_model sl_u (
        .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull)
    );
    // core clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // sequencer sram: one-cycle read, shows junk when not read
    always @(posedge clk) begin
        mem_rdata <= mem_re_q ? mem[mem_addr_q] : ~mem_rdata;
        if (mem_we_q)
            mem[mem_addr_q] <= mem_wdata_q;
    end
    // each stored read byte is matched against the oldest note
    always @(negedge clk) begin
        if (mem_we_q === 1'b1) begin
            if (exp_wr.size() == 0)
                check("stray write", 1, 0);
            else
                check("array write", {mem_addr_q, mem_wdata_q},
                      exp_wr.pop_front());
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic load(input logic [8:0] a);
        foreach (seq_q[i])
            mem[9'(a + i)] = seq_q[i];
    endtask
    // launch a run, keep host traffic going, wait for completion
    task automatic run_seq(input logic [8:0] a, input int n, input logic e);
        logic [7:0] r;
        int i;
        sl_u.starts = 0;
        sl_u.stops = 0;
        sl_u.rx_q.delete();
        sl_u.ack_q.delete();
        start_addr = a;
        sequence_length = 10'(n);
        sl_u.strong_pullup = 1'b1;
        run_start = 1'b1;
        @(negedge clk);
        run_start = 1'b0;
        check("refusal", {err_q, busy_q}, {e, !e});
        if (e)
            return;
        for (i = 0; i < 60000 && done_q !== 1'b1; i++) begin
            check("link gate", {link_rx_ready_q, err_q}, 0);
            r = rnd();
            link_rx_valid = r[0];
            run_start = (i == 50);
            @(negedge clk);
        end
        if (done_q !== 1'b1) begin
            check("run done", 0, 1);
            wrap_up();
        end
        @(negedge clk);
        check("idle again", {busy_q, link_rx_ready_q}, 2'h1);
        sl_u.strong_pullup = 1'b0;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d0, d1, wreg, w2;
        logic [7:0] t[$];
        int k;
        rst = 1'b1;
        {run_start, start_addr, sequence_length, link_rx_valid} = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check("reset state", {busy_q, done_q, err_q, nack_seen_q,
              link_rx_ready_q, mem_we_q, mem_re_q, scl_oe_q, sda_oe_q,
              scl_out_q, sda_out_q}, 11'h040);
        d0 = rnd();
        d1 = rnd();
        wreg = rnd();
        w2 = rnd();
        // address and register write, repeated start, two-byte read
        seq_q = '{8'h02, 8'hE3, 8'h02, 8'hA0, wreg, 8'h02, 8'hE3, 8'h01,
                  8'hA1, 8'hD4, 8'h02, 8'hFF, 8'hFF, 8'h03};
        load(9'h010);
        sl_u.tx_q = '{d0, d1};
        sl_u.stretch_ns = 10000;
        exp_wr = '{{9'h01B, d0}, {9'h01C, d1}};
        run_seq(9'h010, 14, 1'b0);
        check("bus bytes", {sl_u.rx_q.size() == 3, sl_u.rx_q[0],
              sl_u.rx_q[1], sl_u.rx_q[2]}, {1'b1, 8'hA0, wreg, 8'hA1});
        check("master ack", {sl_u.ack_q.size() == 2, sl_u.ack_q[0],
              sl_u.ack_q[1]}, 3'h4);
        check("conditions", {sl_u.starts[3:0], sl_u.stops[3:0]}, 8'h21);
        check("array filled", {nack_seen_q, exp_wr.size() != 0},
              0);
        // slave refuses the data byte
        seq_q = '{8'h02, 8'hE3, 8'h02, 8'hA0, w2, 8'h03};
        load(9'h100);
        sl_u.nack_en = 1'b1;
        sl_u.stretch_ns = 0;
        run_seq(9'h100, 6, 1'b0);
        check("nack flag", nack_seen_q, 1);
        check("nacked bytes", {sl_u.rx_q.size() == 2, sl_u.rx_q[1],
              sl_u.stops[3:0]}, {1'b1, w2, 4'h1});
        // last two bytes of memory are legal, one more is not
        sl_u.nack_en = 1'b0;
        seq_q = '{8'h02, 8'h03};
        load(9'h1FE);
        run_seq(9'h1FE, 2, 1'b0);
        check("start stop", {nack_seen_q, sl_u.starts[3:0],
              sl_u.stops[3:0]}, 9'h011);
        run_seq(9'h1FE, 3, 1'b1);
        @(negedge clk);
        check("no run", {busy_q, sl_u.starts[3:0]}, 0);
        // nine-byte read overruns the fifo depth on its way to the array
        seq_q = '{8'h02, 8'hE3, 8'h01, 8'hA1, 8'hD4, 8'h09};
        for (k = 0; k < 9; k++) begin
            t.push_back(rnd());
            seq_q.push_back(8'hFF);
            exp_wr.push_back({9'(9'h046 + k), t[k]});
        end
        seq_q.push_back(8'h03);
        load(9'h040);
        sl_u.tx_q = t;
        run_seq(9'h040, 16, 1'b0);
        for (k = 0; k < 9; k++)
            check("read slot", mem[9'(9'h046 + k)], t[k]);
        check("long acks", sl_u.ack_q.size(), 9);
        check("long drained", exp_wr.size(), 0);
        check("long frame", {sl_u.starts[3:0], sl_u.stops[3:0]},
              8'h11);
        wrap_up();
    end
endmodule
